/* File: verilog/lpm_pkg.sv */
// package for the lvds pixel bit mapper: lane widths, selections, timing counts
// assumes a 25 MHz system clock and a link pixel clock of 20 to 90 MHz
package lpm_pkg;
    localparam int LANE_W = 7;
    localparam int COLOUR_W = 10;
    localparam int SEL_W = 2;
    // ---------------------------------------------
    // lane bit positions
    // ---------------------------------------------
    localparam int BIT_VALID = 6;
    localparam int BIT_VSYNC = 5;
    localparam int BIT_HSYNC = 4;
    localparam int BIT_FIELD = 6;
    // ---------------------------------------------
    // timing
    // ---------------------------------------------
    localparam int STARTUP_US = 1000;
    localparam int SYS_MHZ = 25;
    localparam int STARTUP_CYC = STARTUP_US * SYS_MHZ;
    localparam int LINK_CYC_MIN = 2;

    typedef enum logic [1:0] {
        LPM_SEL_ONE,
        LPM_SEL_TWO,
        LPM_SEL_THREE,
        LPM_SEL_FOUR
    } lpm_sel_e;

    typedef struct packed {
        logic [LANE_W-1:0] lane_a_bits;
        logic [LANE_W-1:0] lane_b_bits;
        logic [LANE_W-1:0] lane_c_bits;
        logic [LANE_W-1:0] lane_d_bits;
        logic [LANE_W-1:0] lane_e_bits;
    } lpm_lanes_s;

    typedef struct packed {
        logic [COLOUR_W-1:0] red_component;
        logic [COLOUR_W-1:0] green_component;
        logic [COLOUR_W-1:0] blue_component;
        logic pixel_valid;
        logic vsync;
        logic hsync;
        logic field_one;
        logic field_two;
    } lpm_pixel_s;

    localparam lpm_pixel_s PIXEL_RST = '0;
endpackage : lpm_pkg

/* File: verilog/lpm_mapper.sv */
// lvds pixel bit mapper: five deserialised lanes onto 10-bit rgb plus syncs
// assumes lanes are already deserialised and stable on link_pixel_clock;
// the selection and open-input status are plain ports on the system clock.
`timescale 1ns/1ps
module lpm_mapper
    import lpm_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYC
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic link_pixel_clock,
    input wire lpm_lanes_s lanes,
    input wire logic [SEL_W-1:0] map_select,
    input wire logic low_common_mode,
    input wire logic small_swing,
    output lpm_pixel_s pixel,
    output logic link_ready,
    output logic open_input
);
    // ---------------------------------------------
    // system side: selection and status
    // ---------------------------------------------
    lpm_sel_e sel_sys;
    logic [1:0] lcm_sync;
    logic open_input_r;
    localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_END = CNT_W'(STARTUP_CYCLES);
    logic [CNT_W-1:0] start_cnt;
    logic link_toggle;
    logic [2:0] tog_sync;
    logic ready_sys;
    wire start_done = start_cnt == CNT_END;
    wire link_alive = tog_sync[2] ^ tog_sync[1];
    // once begun the count runs by itself, so a slow link is not re-armed
    wire count_run = link_alive || start_cnt != '0;

    always_ff @(posedge clock) begin
        if (srst) begin
            sel_sys <= LPM_SEL_ONE;
        end else begin
            sel_sys <= lpm_sel_e'(map_select);
        end
    end

    // open input depends on common mode only; swing is deliberately unused
    always_ff @(posedge clock) begin
        if (srst) begin
            lcm_sync <= 2'h0;
            open_input_r <= 1'b0;
        end else begin
            lcm_sync <= {lcm_sync[0], low_common_mode};
            open_input_r <= lcm_sync[1];
        end
    end

    // link activity seen as a toggle from the link domain; start-up counts
    // system cycles from the first activity; open input clears the count and readiness
    always_ff @(posedge clock) begin
        if (srst) begin
            tog_sync <= 3'h0;
            start_cnt <= '0;
            ready_sys <= 1'b0;
        end else begin
            tog_sync <= {tog_sync[1:0], link_toggle};
            if (open_input_r) begin
                start_cnt <= '0;
                ready_sys <= 1'b0;
            end else if (start_done) begin
                ready_sys <= 1'b1;
            end else if (count_run) begin
                start_cnt <= start_cnt + CNT_W'(1);
            end
        end
    end

    assign link_ready = ready_sys;
    assign open_input = open_input_r;

    // ---------------------------------------------
    // link side: toggle and mapping
    // ---------------------------------------------
    logic [1:0] rst_link_sync;
    logic [1:0] sel_link_meta;
    logic [1:0] sel_link_sync;
    logic [1:0] sel_link_prev;
    logic [1:0] sel_link;
    logic [1:0] rdy_link_sync;
    lpm_pixel_s pixel_r;
    // the link side has no reset pin of its own, so the system reset is carried over
    wire link_rst = rst_link_sync[1];
    // both selection bits must agree on two link edges before they are applied;
    // a two-bit change that lands across an edge is never used half done
    wire sel_settled = sel_link_sync == sel_link_prev;
    wire [1:0] next_sel_link = sel_settled ? sel_link_prev : sel_link;
    wire sel_one_on = rdy_link_sync[1] && sel_link == 2'h0;
    wire sel_two_on = rdy_link_sync[1] && sel_link == 2'h1;
    wire sel_three_on = rdy_link_sync[1] && sel_link == 2'h2;
    wire sel_four_on = rdy_link_sync[1] && sel_link == 2'h3;

    always_ff @(posedge link_pixel_clock) begin
        rst_link_sync <= {rst_link_sync[0], srst};
    end

    // selection is quasi-static: a change may switch the mapping mid-frame, never within one pixel, accepted
    // because software changes it only between sources
    always_ff @(posedge link_pixel_clock) begin
        if (link_rst) begin
            link_toggle <= 1'b0;
            sel_link_meta <= 2'h0;
            sel_link_sync <= 2'h0;
            sel_link_prev <= 2'h0;
            sel_link <= 2'h0;
            rdy_link_sync <= 2'h0;
        end else begin
            link_toggle <= ~link_toggle;
            sel_link_meta <= sel_sys;
            sel_link_sync <= sel_link_meta;
            sel_link_prev <= sel_link_sync;
            sel_link <= next_sel_link;
            rdy_link_sync <= {rdy_link_sync[0], ready_sys};
        end
    end

    function automatic lpm_pixel_s map_lanes(input lpm_lanes_s l, input logic [1:0] s);
        lpm_pixel_s p;
        p = '0;
        p.pixel_valid = l.lane_c_bits[BIT_VALID];
        p.vsync = l.lane_c_bits[BIT_VSYNC];
        p.hsync = l.lane_c_bits[BIT_HSYNC];
        p.field_one = l.lane_d_bits[BIT_FIELD];
        p.field_two = l.lane_e_bits[BIT_FIELD];
        case (lpm_sel_e'(s))
            LPM_SEL_ONE: begin
                p.red_component = {l.lane_a_bits[5:0], l.lane_d_bits[1:0],
                    l.lane_e_bits[1:0]};
                p.green_component = {l.lane_b_bits[4:0], l.lane_a_bits[6],
                    l.lane_d_bits[3:2], l.lane_e_bits[3:2]};
                p.blue_component = {l.lane_c_bits[3:0], l.lane_b_bits[6:5],
                    l.lane_d_bits[5:4], l.lane_e_bits[5:4]};
            end
            LPM_SEL_TWO: begin
                p.red_component = {l.lane_d_bits[1:0], l.lane_a_bits[5:0], 2'h0};
                p.green_component = {l.lane_d_bits[3:2], l.lane_b_bits[4:0],
                    l.lane_a_bits[6], 2'h0};
                p.blue_component = {l.lane_d_bits[5:4], l.lane_c_bits[3:0],
                    l.lane_b_bits[6:5], 2'h0};
            end
            LPM_SEL_THREE: begin
                p.red_component = {l.lane_e_bits[1:0], l.lane_d_bits[1:0],
                    l.lane_a_bits[5:0]};
                p.green_component = {l.lane_e_bits[3:2], l.lane_d_bits[3:2],
                    l.lane_b_bits[4:0], l.lane_a_bits[6]};
                p.blue_component = {l.lane_e_bits[5:4], l.lane_d_bits[5:4],
                    l.lane_c_bits[3:0], l.lane_b_bits[6:5]};
            end
            LPM_SEL_FOUR: begin
                // 18-bit mode, lanes D and E colour bits unused
                p.red_component = {l.lane_a_bits[5:0], 4'h0};
                p.green_component = {l.lane_b_bits[4:0], l.lane_a_bits[6], 4'h0};
                p.blue_component = {l.lane_c_bits[3:0], l.lane_b_bits[6:5], 4'h0};
            end
            default: begin
                p.red_component = '0;
            end
        endcase
        return p;
    endfunction : map_lanes

    wire lpm_pixel_s next_pixel = map_lanes(lanes, sel_link);

    // pixels pass only once start-up is complete; before that all zero
    always_ff @(posedge link_pixel_clock) begin
        if (rdy_link_sync[1]) begin
            pixel_r <= next_pixel;
        end else begin
            pixel_r <= PIXEL_RST;
        end
    end

    assign pixel = pixel_r;

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    a_valid_from_lane: assert property (@(posedge link_pixel_clock)
        rdy_link_sync[1] |=> pixel_r.pixel_valid == $past(lanes.lane_c_bits[BIT_VALID]))
        else $error("pixel valid not taken from lane c bit 6");
    a_sync_from_lane: assert property (@(posedge link_pixel_clock)
        rdy_link_sync[1]
        |=> {pixel_r.vsync, pixel_r.hsync} == $past(lanes.lane_c_bits[BIT_VSYNC:BIT_HSYNC]))
        else $error("syncs not taken from lane c bits 5 and 4");
    a_field_bits: assert property (@(posedge link_pixel_clock)
        rdy_link_sync[1] |=> pixel_r.field_two == $past(lanes.lane_e_bits[BIT_FIELD]))
        else $error("field two not from lane e bit 6");
    a_field_one: assert property (@(posedge link_pixel_clock)
        rdy_link_sync[1] |=> pixel_r.field_one == $past(lanes.lane_d_bits[BIT_FIELD]))
        else $error("field one not from lane d bit 6");
    a_sel_one_red: assert property (@(posedge link_pixel_clock)
        sel_one_on
        |=> pixel_r.red_component == $past({lanes.lane_a_bits[5:0], lanes.lane_d_bits[1:0],
            lanes.lane_e_bits[1:0]}))
        else $error("selection one red wrong");
    a_sel_one_green: assert property (@(posedge link_pixel_clock)
        sel_one_on
        |=> pixel_r.green_component == $past({lanes.lane_b_bits[4:0], lanes.lane_a_bits[6],
            lanes.lane_d_bits[3:2], lanes.lane_e_bits[3:2]}))
        else $error("selection one green wrong");
    a_sel_one_blue: assert property (@(posedge link_pixel_clock)
        sel_one_on
        |=> pixel_r.blue_component == $past({lanes.lane_c_bits[3:0], lanes.lane_b_bits[6:5],
            lanes.lane_d_bits[5:4], lanes.lane_e_bits[5:4]}))
        else $error("selection one blue wrong");
    a_sel_two_red: assert property (@(posedge link_pixel_clock)
        sel_two_on
        |=> pixel_r.red_component[9:2]
            == $past({lanes.lane_d_bits[1:0], lanes.lane_a_bits[5:0]}))
        else $error("selection two red wrong");
    a_sel_two_green: assert property (@(posedge link_pixel_clock)
        sel_two_on
        |=> pixel_r.green_component[9:2]
            == $past({lanes.lane_d_bits[3:2], lanes.lane_b_bits[4:0], lanes.lane_a_bits[6]}))
        else $error("selection two green wrong");
    a_sel_two_blue: assert property (@(posedge link_pixel_clock)
        sel_two_on
        |=> pixel_r.blue_component[9:2]
            == $past({lanes.lane_d_bits[5:4], lanes.lane_c_bits[3:0], lanes.lane_b_bits[6:5]}))
        else $error("selection two blue wrong");
    a_sel_two_low: assert property (@(posedge link_pixel_clock)
        sel_two_on |=> {pixel_r.red_component[1:0], pixel_r.green_component[1:0],
            pixel_r.blue_component[1:0]} == 6'h00)
        else $error("unsourced colour bits not zero");
    a_sel_three_red: assert property (@(posedge link_pixel_clock)
        sel_three_on
        |=> pixel_r.red_component == $past({lanes.lane_e_bits[1:0], lanes.lane_d_bits[1:0],
            lanes.lane_a_bits[5:0]}))
        else $error("selection three red wrong");
    a_sel_three_green: assert property (@(posedge link_pixel_clock)
        sel_three_on
        |=> pixel_r.green_component == $past({lanes.lane_e_bits[3:2], lanes.lane_d_bits[3:2],
            lanes.lane_b_bits[4:0], lanes.lane_a_bits[6]}))
        else $error("selection three green wrong");
    a_sel_three_blue: assert property (@(posedge link_pixel_clock)
        sel_three_on
        |=> pixel_r.blue_component == $past({lanes.lane_e_bits[5:4], lanes.lane_d_bits[5:4],
            lanes.lane_c_bits[3:0], lanes.lane_b_bits[6:5]}))
        else $error("selection three blue wrong");
    a_sel_four_high: assert property (@(posedge link_pixel_clock)
        sel_four_on
        |=> {pixel_r.red_component[9:4], pixel_r.green_component[9:4],
            pixel_r.blue_component[9:4]} == $past({lanes.lane_a_bits[5:0],
            lanes.lane_b_bits[4:0], lanes.lane_a_bits[6], lanes.lane_c_bits[3:0],
            lanes.lane_b_bits[6:5]}))
        else $error("18-bit mode high colour bits wrong");
    a_sel_four_low: assert property (@(posedge link_pixel_clock)
        sel_four_on |=> {pixel_r.red_component[3:0], pixel_r.green_component[3:0],
            pixel_r.blue_component[3:0]} == 12'h000)
        else $error("lane d or e leaked into 18-bit mode");
    a_idle_zero: assert property (@(posedge link_pixel_clock)
        !rdy_link_sync[1] |=> pixel_r == PIXEL_RST)
        else $error("pixel passed before start-up complete");
    a_sel_applied: assert property (@(posedge link_pixel_clock) disable iff (link_rst)
        sel_link != $past(sel_link) |-> $past(sel_link_sync == sel_link_prev))
        else $error("selection applied before both bits settled");

    // ---------------------------------------------
    // system side checks
    // ---------------------------------------------
    a_open_input: assert property (@(posedge clock) disable iff (srst)
        !$past(srst) && !$past(srst, 2) && !$past(srst, 3)
        |-> open_input_r == $past(low_common_mode, 3))
        else $error("open input not following common mode");
    a_ready_clear: assert property (@(posedge clock) disable iff (srst)
        open_input_r |=> !ready_sys)
        else $error("ready held with open input");
    a_ready_late: assert property (@(posedge clock) disable iff (srst)
        $rose(ready_sys) |-> $past(start_done))
        else $error("ready raised before the start-up count ended");
    a_count_step: assert property (@(posedge clock) disable iff (srst)
        !srst && !open_input_r && !start_done && count_run
        |=> start_cnt == $past(start_cnt) + 1'b1)
        else $error("start-up count did not advance");
    a_sel_follow: assert property (@(posedge clock) disable iff (srst)
        ##1 sel_sys == $past(map_select))
        else $error("selection not taken from setting");
    c_sel_two: cover property (@(posedge link_pixel_clock) sel_two_on);
    c_sel_three: cover property (@(posedge link_pixel_clock) sel_three_on);
    c_sel_four: cover property (@(posedge link_pixel_clock) sel_four_on);
    c_ready: cover property (@(posedge clock) disable iff (srst) $rose(ready_sys));
    c_open: cover property (@(posedge clock) disable iff (srst) $rose(open_input_r));
endmodule : lpm_mapper

/* File: sim/lpm_tx_model.sv */
// model of the external video transmitter feeding the pixel bit mapper
// assumes the receiver samples lanes on the rising link clock edge
`timescale 1ns/1ps
module lpm_tx_model
    import lpm_pkg::*;
(
    output logic link_pixel_clock,
    output lpm_lanes_s lanes
);
    int seed;
    logic [63:0] draw;
    // ---------------------------------------------
    // link clock, 32 ns, free running once started
    // ---------------------------------------------
    initial begin
        seed = 32'h7733a2bd;
        link_pixel_clock = 1'b0;
        lanes = '0;
        // odd offset keeps the link edges unrelated to the system clock
        #7;
        forever #16 link_pixel_clock = ~link_pixel_clock;
    end
    // ---------------------------------------------
    // lane data, changed just after each rising edge
    // ---------------------------------------------
    always @(posedge link_pixel_clock) begin
        draw = {$random(seed), $random(seed)};
        lanes <= #1 draw[34:0];
    end
endmodule : lpm_tx_model

/* File: sim/testbench.sv */
// self-checking bench for the pixel bit mapper with a random lane stream
// assumes a transmitter model on the link side and a short start-up count
`timescale 1ns/1ps
module testbench;
    import lpm_pkg::*;
    localparam int START = 20;
    logic clock, srst, link_pixel_clock, low_common_mode, small_swing;
    logic link_ready, open_input;
    logic [SEL_W-1:0] map_select;
    lpm_lanes_s lanes, last;
    lpm_pixel_s pixel;
    int errors, checks, seed, n;
    lpm_mapper #(.STARTUP_CYCLES(START)) lpm_mapper_inst (.clock(clock), .srst(srst),
        .link_pixel_clock(link_pixel_clock), .lanes(lanes), .map_select(map_select),
        .low_common_mode(low_common_mode), .small_swing(small_swing), .pixel(pixel),
        .link_ready(link_ready), .open_input(open_input));
    lpm_tx_model lpm_tx_model_inst (.link_pixel_clock(link_pixel_clock), .lanes(lanes));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // ---------------------------------------------
    // expectations and checks
    // ---------------------------------------------
    function automatic lpm_pixel_s exp_map(lpm_lanes_s l, logic [SEL_W-1:0] s);
        lpm_pixel_s p;
        logic [6:0] a, b, c, d, e;
        {a, b, c, d, e} = l;
        p = '0;
        {p.pixel_valid, p.vsync, p.hsync} = c[6:4];
        {p.field_one, p.field_two} = {d[6], e[6]};
        case (s)
            2'h0: begin
                {p.red_component, p.green_component} = {a[5:0], d[1:0], e[1:0],
                    b[4:0], a[6], d[3:2], e[3:2]};
                p.blue_component = {c[3:0], b[6:5], d[5:4], e[5:4]};
            end
            2'h1: begin
                {p.red_component, p.green_component} = {d[1:0], a[5:0], 2'h0,
                    d[3:2], b[4:0], a[6], 2'h0};
                p.blue_component = {d[5:4], c[3:0], b[6:5], 2'h0};
            end
            2'h2: begin
                {p.red_component, p.green_component} = {e[1:0], d[1:0], a[5:0],
                    e[3:2], d[3:2], b[4:0], a[6]};
                p.blue_component = {e[5:4], d[5:4], c[3:0], b[6:5]};
            end
            default: begin
                {p.red_component, p.green_component} = {a[5:0], 4'h0, b[4:0], a[6], 4'h0};
                p.blue_component = {c[3:0], b[6:5], 4'h0};
            end
        endcase
        return p;
    endfunction : exp_map
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        if (errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic wait_ready();
        for (n = 0; n < START + 40 && link_ready !== 1'b1; n++) @(negedge clock);
        if (link_ready !== 1'b1) begin
            chk(link_ready, 1'b1);
            end_of_test();
        end
    endtask : wait_ready
    // selection settles through the link synchroniser, then 40 pixels are compared
    task automatic run_sel(input logic [SEL_W-1:0] s);
        @(negedge clock);
        map_select = s;
        repeat (6) @(posedge link_pixel_clock);
        #4 last = lanes;
        repeat (40) begin
            @(posedge link_pixel_clock);
            #4 chk(pixel, exp_map(last, s));
            last = lanes;
        end
    endtask : run_sel
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        seed = 32'h7733a2bd;
        {errors, checks} = '0;
        {srst, map_select, low_common_mode, small_swing} = {1'b1, 2'h0, 1'b0, 1'b0};
        repeat (10) @(posedge clock);
        @(negedge clock);
        srst = 1'b0;
        @(negedge clock);
        chk(link_ready, 1'b0);
        chk(pixel, PIXEL_RST);
        wait_ready();
        chk(n >= START - 1, 1'b1);
        for (int k = 0; k < 20; k++) begin
            @(negedge clock);
            small_swing = 1'($random(seed));
            chk(open_input, 1'b0);
        end
        for (int s = 0; s < 4; s++) run_sel(2'(s));
        // open input must drop readiness and restart the start-up count
        @(negedge clock);
        low_common_mode = 1'b1;
        repeat (4) @(negedge clock);
        chk(open_input, 1'b1);
        chk(link_ready, 1'b0);
        low_common_mode = 1'b0;
        wait_ready();
        run_sel(2'h3);
        run_sel(2'h1);
        end_of_test();
    end
endmodule : testbench
